/* File: verilog/ldt_pkg.sv */
package ldt_pkg;

  // ****************************************************************
  // bus and command codes
  // ****************************************************************
  localparam int         DATA_W           = 18;
  localparam logic [7:0] CMD_READ_CONT    = 8'h3e;
  localparam logic [7:0] CMD_TEAR_LINE    = 8'h44;
  localparam logic [7:0] CMD_GET_SCAN     = 8'h45;
  localparam logic [7:0] CMD_WRITE_BRIGHT = 8'h51;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         LINE_HI_BIT      = 0;
  localparam int         LINE_W           = 9;
  localparam int         BRIGHT_W         = 8;
  localparam logic [8:0] TEAR_LINE_RESET  = 9'h000;
  localparam logic [7:0] BRIGHT_RESET     = 8'h00;

  // ****************************************************************
  // vertical timing
  // ****************************************************************
  localparam int VSYNC_LINES                = 2;
  localparam int vertical_back_porch_lines  = 4;
  localparam int vertical_active_lines      = 432;
  localparam int vertical_front_porch_lines = 4;
  localparam int TOTAL_LINES = VSYNC_LINES + vertical_back_porch_lines
                             + vertical_active_lines + vertical_front_porch_lines;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINE_TIME_NS  = 32000;
  localparam int LINE_CLKS     = LINE_TIME_NS / CLK_PERIOD_NS;
  localparam int SCAN_WAIT_NS  = 3000;
  localparam int SCAN_WAIT_CLKS = (SCAN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_RC_DUMMY, ST_RC_DATA, ST_RC_END, ST_TS_P1, ST_TS_P2,
    ST_GS_DUMMY, ST_GS_HI, ST_GS_LO, ST_BR_P1
  } ldt_state_e;

  typedef struct packed {
    logic              cmd_data_select;
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic [DATA_W-1:0] data;
  } ldt_host_in_s;

  typedef struct packed {
    logic [8:0] start_column;
    logic [8:0] end_column;
    logic [8:0] start_page;
    logic [8:0] end_page;
  } ldt_window_s;

endpackage

/* File: verilog/ldt_scan_timer.sv */
module ldt_scan_timer (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // scan position
  output logic [8:0]      scan_line,
  output logic            line_start
);

  localparam logic [11:0] LINE_LAST = 12'(ldt_pkg::LINE_CLKS - 1);
  localparam logic [8:0]  SCAN_LAST = 9'(ldt_pkg::TOTAL_LINES - 1);

  logic [11:0] tick;
  logic [11:0] next_tick;
  logic [8:0]  next_scan_line;
  logic        next_line_start;

  // line zero is the first sync line; count runs through all porches
  always_comb begin
    next_tick       = tick + 12'h001;
    next_scan_line  = scan_line;
    next_line_start = 1'b0;
    if (tick == LINE_LAST) begin
      next_tick       = 12'h000;
      next_line_start = 1'b1;
      next_scan_line  = (scan_line == SCAN_LAST) ? 9'h000 : scan_line + 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick       <= 12'h000;
      scan_line  <= 9'h000;
      line_start <= 1'b0;
    end else begin
      tick       <= next_tick;
      scan_line  <= next_scan_line;
      line_start <= next_line_start;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  scan_wrap_a: assert property (
    (scan_line == SCAN_LAST && tick == LINE_LAST) |=> (scan_line == 9'h000 && line_start))
    else $error("scan line did not wrap to zero");

  scan_step_a: assert property (
    (scan_line != SCAN_LAST && tick == LINE_LAST)
    |=> (scan_line == $past(scan_line) + 9'h001 && line_start))
    else $error("scan line did not step");

endmodule

/* File: verilog/ldt_cmd_core.sv */
module ldt_cmd_core (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // host parallel bus
  input  wire ldt_pkg::ldt_host_in_s host_in,
  output logic [ldt_pkg::DATA_W-1:0] data_out,
  output logic                      data_oe,
  // shared address window and mode
  input  wire ldt_pkg::ldt_window_s  win,
  input  wire logic                 row_column_exchange_bit,
  input  wire logic                 rd_start,
  // power and reset events
  input  wire logic                 sleep_in,
  input  wire logic                 soft_reset,
  // frame memory read port
  output logic [8:0]                fm_col,
  output logic [8:0]                fm_page,
  input  wire logic [ldt_pkg::DATA_W-1:0] fm_data,
  // display controls
  output logic                      tearing_effect_out,
  output logic [7:0]                brightness_value
);

  // ****************************************************************
  // strobe edges
  // ****************************************************************
  logic wr_q;
  logic rd_q;
  logic wr_rise;
  logic rd_rise;
  logic rd_fall;
  logic cmd_take;
  logic par_take;
  logic rd_word_fall;
  logic rd_word_rise;

  assign wr_rise      = !wr_q && host_in.write_strobe_n;
  assign rd_rise      = !rd_q && host_in.read_strobe_n;
  assign rd_fall      = rd_q && !host_in.read_strobe_n;
  assign cmd_take     = wr_rise && !host_in.cmd_data_select;
  assign par_take     = wr_rise && host_in.cmd_data_select;
  assign rd_word_fall = rd_fall && host_in.cmd_data_select;
  assign rd_word_rise = rd_rise && host_in.cmd_data_select;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end else begin
      wr_q <= host_in.write_strobe_n;
      rd_q <= host_in.read_strobe_n;
    end
  end

  // ****************************************************************
  // scan line source
  // ****************************************************************
  logic [8:0] scan_line;

  ldt_scan_timer u_scan (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .scan_line  (scan_line),
    .line_start ()
  );

  function automatic logic [8:0] step9(input logic [8:0] v);
    return v + 9'h001;
  endfunction

  // ****************************************************************
  // command state and registers
  // ****************************************************************
  ldt_pkg::ldt_state_e              state;
  ldt_pkg::ldt_state_e              next_state;
  logic [8:0]                       next_fm_col;
  logic [8:0]                       next_fm_page;
  logic                             tear_hi;
  logic                             next_tear_hi;
  logic [8:0]                       tear_line;
  logic [8:0]                       next_tear_line;
  logic                             tear_en;
  logic                             next_tear_en;
  logic [7:0]                       next_brightness_value;
  logic [8:0]                       scan_hold;
  logic [8:0]                       next_scan_hold;
  logic [ldt_pkg::DATA_W-1:0]       next_data_out;
  logic                             next_data_oe;
  logic                             next_te;

  always_comb begin
    next_state            = state;
    next_fm_col           = fm_col;
    next_fm_page          = fm_page;
    next_tear_hi          = tear_hi;
    next_tear_line        = tear_line;
    next_tear_en          = tear_en;
    next_brightness_value = brightness_value;
    next_scan_hold        = scan_hold;
    next_data_out         = data_out;
    next_data_oe          = data_oe;
    // read start elsewhere rewinds the shared pointer
    if (rd_start) begin
      next_fm_col  = win.start_column;
      next_fm_page = win.start_page;
    end
    // no power-state gating: read, tear and scan commands work in sleep too; sleep_in clears any brightness write
    if (cmd_take) begin
      case (host_in.data[7:0])
        ldt_pkg::CMD_READ_CONT:    next_state = ldt_pkg::ST_RC_DUMMY;
        ldt_pkg::CMD_TEAR_LINE:    next_state = ldt_pkg::ST_TS_P1;
        ldt_pkg::CMD_GET_SCAN:     next_state = ldt_pkg::ST_GS_DUMMY;
        ldt_pkg::CMD_WRITE_BRIGHT: next_state = ldt_pkg::ST_BR_P1;
        default:                   next_state = ldt_pkg::ST_IDLE;
      endcase
    end else if (par_take) begin
      case (state)
        ldt_pkg::ST_TS_P1: begin
          next_tear_hi = host_in.data[ldt_pkg::LINE_HI_BIT];
          next_state   = ldt_pkg::ST_TS_P2;
        end
        ldt_pkg::ST_TS_P2: begin
          next_tear_line = {tear_hi, host_in.data[7:0]};
          next_tear_en   = 1'b1;
          next_state     = ldt_pkg::ST_IDLE;
        end
        ldt_pkg::ST_BR_P1: begin
          next_brightness_value = host_in.data[7:0];
          next_state            = ldt_pkg::ST_IDLE;
        end
        default: ;
      endcase
    end
    // word is placed on the bus at the falling read edge
    if (rd_word_fall) begin
      next_data_oe = 1'b1;
      case (state)
        ldt_pkg::ST_RC_DATA: next_data_out = fm_data;
        ldt_pkg::ST_GS_DUMMY: begin
          next_data_out  = '0;
          next_scan_hold = scan_line;
        end
        ldt_pkg::ST_GS_HI:   next_data_out = {17'h00000, scan_hold[8]};
        ldt_pkg::ST_GS_LO:   next_data_out = {10'h000, scan_hold[7:0]};
        default:             next_data_out = '0;
      endcase
    end
    if (rd_rise) begin
      next_data_oe = 1'b0;
    end
    if (rd_word_rise) begin
      case (state)
        ldt_pkg::ST_RC_DUMMY: next_state = ldt_pkg::ST_RC_DATA;
        ldt_pkg::ST_RC_DATA: begin
          if (!row_column_exchange_bit) begin
            if (fm_col == win.end_column) begin
              if (fm_page == win.end_page) begin
                next_state = ldt_pkg::ST_RC_END;
              end else begin
                next_fm_col  = win.start_column;
                next_fm_page = step9(fm_page);
              end
            end else begin
              next_fm_col = step9(fm_col);
            end
          end else begin
            if (fm_page == win.end_page) begin
              if (fm_col == win.end_column) begin
                next_state = ldt_pkg::ST_RC_END;
              end else begin
                next_fm_page = win.start_page;
                next_fm_col  = step9(fm_col);
              end
            end else begin
              next_fm_page = step9(fm_page);
            end
          end
        end
        ldt_pkg::ST_GS_DUMMY: next_state = ldt_pkg::ST_GS_HI;
        ldt_pkg::ST_GS_HI:    next_state = ldt_pkg::ST_GS_LO;
        ldt_pkg::ST_GS_LO:    next_state = ldt_pkg::ST_IDLE;
        default: ;
      endcase
    end
    if (sleep_in) begin
      next_brightness_value = ldt_pkg::BRIGHT_RESET;
    end
    if (soft_reset) begin
      next_tear_line        = ldt_pkg::TEAR_LINE_RESET;
      next_tear_en          = 1'b0;
      next_brightness_value = ldt_pkg::BRIGHT_RESET;
      next_state            = ldt_pkg::ST_IDLE;
    end
    // refresh order bit deliberately not an input here
    next_te = tear_en && (scan_line == tear_line);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ldt_pkg::ST_IDLE;
      fm_col             <= 9'h000;
      fm_page            <= 9'h000;
      tear_hi            <= 1'b0;
      tear_line          <= ldt_pkg::TEAR_LINE_RESET;
      tear_en            <= 1'b0;
      brightness_value   <= ldt_pkg::BRIGHT_RESET;
      scan_hold          <= 9'h000;
      data_out           <= '0;
      data_oe            <= 1'b0;
      tearing_effect_out <= 1'b0;
    end else begin
      state              <= next_state;
      fm_col             <= next_fm_col;
      fm_page            <= next_fm_page;
      tear_hi            <= next_tear_hi;
      tear_line          <= next_tear_line;
      tear_en            <= next_tear_en;
      brightness_value   <= next_brightness_value;
      scan_hold          <= next_scan_hold;
      data_out           <= next_data_out;
      data_oe            <= next_data_oe;
      tearing_effect_out <= next_te;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence rc_step_s;
    state == ldt_pkg::ST_RC_DATA && rd_word_rise && !rd_start && !soft_reset;
  endsequence

  sequence normal_order_s;
    !row_column_exchange_bit;
  endsequence

  rc_dummy_a: assert property (
    (state == ldt_pkg::ST_RC_DUMMY && rd_word_rise && !soft_reset)
    |=> state == ldt_pkg::ST_RC_DATA)
    else $error("dummy read did not lead to pixel data");

  rc_pixel_a: assert property (
    (state == ldt_pkg::ST_RC_DATA && rd_word_fall)
    |=> (data_out == $past(fm_data) && data_oe))
    else $error("pixel word not presented");

  col_step_a: assert property (
    (rc_step_s and normal_order_s) ##0 (fm_col != win.end_column)
    |=> fm_col == $past(fm_col) + 9'h001)
    else $error("column did not advance");

  col_wrap_a: assert property (
    (rc_step_s and normal_order_s) ##0
    (fm_col == win.end_column && fm_page != win.end_page)
    |=> (fm_col == $past(win.start_column) && fm_page == $past(fm_page) + 9'h001))
    else $error("column wrap or page step wrong");

  rc_end_a: assert property (
    (rc_step_s and normal_order_s) ##0
    (fm_col == win.end_column && fm_page == win.end_page)
    |=> state == ldt_pkg::ST_RC_END)
    else $error("read did not stop at window end");

  cmd_abort_a: assert property (
    (cmd_take && state == ldt_pkg::ST_RC_DATA)
    |=> state != ldt_pkg::ST_RC_DATA)
    else $error("new command did not end the read");

  tear_load_a: assert property (
    (state == ldt_pkg::ST_TS_P2 && par_take && !soft_reset)
    |=> (tear_en && tear_line == {$past(tear_hi), $past(host_in.data[7:0])}))
    else $error("tear line not loaded");

  te_match_a: assert property (
    (tear_en && scan_line == tear_line) |=> tearing_effect_out)
    else $error("tearing output missed its line");

  te_quiet_a: assert property (
    !tear_en |=> !tearing_effect_out)
    else $error("tearing output while disabled");

  scan_words_a: assert property (
    (state == ldt_pkg::ST_GS_HI && rd_word_fall)
    |=> data_out == {17'h00000, scan_hold[8]})
    else $error("scan line high word wrong");

  bright_load_a: assert property (
    (state == ldt_pkg::ST_BR_P1 && par_take && !sleep_in && !soft_reset)
    |=> brightness_value == $past(host_in.data[7:0]))
    else $error("brightness not loaded");

  sleep_clear_a: assert property (
    sleep_in |=> brightness_value == 8'h00)
    else $error("brightness kept in sleep");

  soft_reset_a: assert property (
    soft_reset |=> (tear_line == 9'h000 && !tear_en && brightness_value == 8'h00))
    else $error("soft reset left settings");

endmodule

/* File: sim/ldt_host_model.sv */
// ****************************************************************
// host processor on the parallel command bus
// ****************************************************************
module ldt_host_model (
  // clock
  input  wire logic                       clk_sys,
  // host bus
  output ldt_pkg::ldt_host_in_s           host_in,
  input  wire logic [ldt_pkg::DATA_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_in = {1'b1, 1'b1, 1'b1, 18'h00000};
  end

  // select low for commands, high for parameters; taken at strobe rise
  task automatic wr(input logic dcx, input logic [7:0] val);
    @(posedge clk_sys);
    host_in.cmd_data_select <= dcx;
    host_in.data            <= {10'h000, val};
    host_in.write_strobe_n  <= 1'b0;
    @(posedge clk_sys);
    host_in.write_strobe_n  <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  // bus released while reading: drive the inverse of the last word
  task automatic rd(output logic [17:0] word);
    @(posedge clk_sys);
    host_in.cmd_data_select <= 1'b1;
    host_in.data            <= ~host_in.data;
    host_in.read_strobe_n   <= 1'b0;
    repeat (2) @(posedge clk_sys);
    word = data_out;
    host_in.read_strobe_n   <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  // scan line query with the settling wait before the reads
  task automatic scan(output logic [17:0] w0, output logic [17:0] w1, output logic [17:0] w2);
    wr(1'b0, ldt_pkg::CMD_GET_SCAN);
    repeat (ldt_pkg::SCAN_WAIT_CLKS) @(posedge clk_sys);
    rd(w0);
    rd(w1);
    rd(w2);
  endtask
endmodule

/* File: sim/lcd_dcs_readback_tear_brightness_tb.sv */
module lcd_dcs_readback_tear_brightness_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys    = 1'b0;
  logic                  rst_n      = 1'b0;
  ldt_pkg::ldt_host_in_s host_in;
  logic [17:0]           data_out;
  logic                  data_oe;
  ldt_pkg::ldt_window_s  win        = '0;
  logic                  rd_start   = 1'b0;
  logic                  sleep_in   = 1'b0;
  logic                  soft_reset = 1'b0;
  logic                  order_swap = 1'b0;
  logic [8:0]            fm_col;
  logic [8:0]            fm_page;
  logic [17:0]           fm_data;
  logic                  te;
  logic [7:0]            bright;
  int                    num_errors = 0;
  int                    comparisons = 0;

  always #4 clk_sys = ~clk_sys;

  // frame memory: each word is its own column and page
  assign fm_data = {fm_col, fm_page};

  ldt_host_model host (
    .clk_sys  (clk_sys),
    .host_in  (host_in),
    .data_out (data_out)
  );

  ldt_cmd_core dut (
    .clk_sys                 (clk_sys),
    .rst_n                   (rst_n),
    .host_in                 (host_in),
    .data_out                (data_out),
    .data_oe                 (data_oe),
    .win                     (win),
    .row_column_exchange_bit (order_swap),
    .rd_start                (rd_start),
    .sleep_in                (sleep_in),
    .soft_reset              (soft_reset),
    .fm_col                  (fm_col),
    .fm_page                 (fm_page),
    .fm_data                 (fm_data),
    .tearing_effect_out      (te),
    .brightness_value        (bright)
  );

  // ****************************************************************
  // comparisons and verdict
  // ****************************************************************
  task automatic tally(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
    tally(got === exp, "read word");
  endtask
  task automatic check_bright(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, "brightness");
  endtask
  task automatic check_flag(input logic got, input logic exp);
    tally(got === exp, "flag");
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [17:0] pixel(input logic [8:0] c, input logic [8:0] p);
    return {c, p};
  endfunction

  task automatic load_window(input logic [8:0] sc, ec, sp, ep);
    @(posedge clk_sys);
    win      <= {sc, ec, sp, ep};
    rd_start <= 1'b1;
    @(posedge clk_sys);
    rd_start <= 1'b0;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [17:0] w, w1, w2;
    logic [8:0]  sc, ec, sp, ep, c, p, line;
    logic [7:0]  v;
    int          n, t;
    void'($urandom(55));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_bright(bright, 8'h00);
    check_flag(te, 1'b0);
    check_flag(data_oe, 1'b0);
    host.wr(1'b1, 8'h5a);
    check_bright(bright, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      host.wr(1'b0, ldt_pkg::CMD_WRITE_BRIGHT);
      host.wr(1'b1, v);
      check_bright(bright, v);
    end
    host.wr(1'b1, ~v);
    check_bright(bright, v);
    sleep_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sleep_in <= 1'b0;
    check_bright(bright, 8'h00);
    host.wr(1'b0, ldt_pkg::CMD_WRITE_BRIGHT);
    host.wr(1'b1, 8'h3c);
    soft_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    soft_reset <= 1'b0;
    check_bright(bright, 8'h00);
    // window walk, resumed part way by a second read continue
    sc = 9'($urandom_range(5));
    ec = sc + 9'(1 + $urandom_range(2));
    sp = 9'($urandom_range(3));
    ep = sp + 9'(1 + $urandom_range(1));
    load_window(sc, ec, sp, ep);
    host.wr(1'b0, ldt_pkg::CMD_READ_CONT);
    host.rd(w);
    check_word(w, 18'h00000);
    c = sc;
    p = sp;
    n = (ec - sc + 1) * (ep - sp + 1);
    for (int k = 0; k < n; k++) begin
      if (k == n / 2 && k > 0) begin
        host.wr(1'b0, ldt_pkg::CMD_READ_CONT);
        host.rd(w);
        check_word(w, 18'h00000);
      end
      host.rd(w);
      check_word(w, pixel(c, p));
      if (c == ec) begin
        c = sc;
        p++;
      end else c++;
    end
    host.rd(w);
    check_word(w, 18'h00000);
    // another command cuts the read short
    load_window(sc, ec, sp, ep);
    host.wr(1'b0, ldt_pkg::CMD_READ_CONT);
    host.rd(w);
    host.rd(w);
    check_word(w, pixel(sc, sp));
    host.wr(1'b0, ldt_pkg::CMD_WRITE_BRIGHT);
    host.wr(1'b1, 8'h11);
    host.rd(w);
    check_word(w, 18'h00000);
    check_bright(bright, 8'h11);
    // column-major walk (page steps first), cut by an unknown command and resumed
    order_swap <= 1'b1;
    load_window(sc, sc + 9'h001, sp, sp + 9'h001);
    host.wr(1'b0, ldt_pkg::CMD_READ_CONT);
    host.rd(w);
    check_word(w, 18'h00000);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        host.wr(1'b0, 8'h00);
        host.rd(w);
        check_word(w, 18'h00000);
        host.wr(1'b0, ldt_pkg::CMD_READ_CONT);
        host.rd(w);
      end
      host.rd(w);
      check_word(w, pixel(sc + 9'(k / 2), sp + 9'(k % 2)));
    end
    host.rd(w);
    check_word(w, 18'h00000);
    order_swap <= 1'b0;
    // tear line programmed during sleep, then matched by the scan
    line = 9'(1 + $urandom_range(2));
    sleep_in <= 1'b1;
    host.wr(1'b0, ldt_pkg::CMD_TEAR_LINE);
    host.wr(1'b1, {7'h00, line[8]});
    host.wr(1'b1, line[7:0]);
    sleep_in <= 1'b0;
    check_flag(te, 1'b0);
    for (t = 0; t < 20000 && te !== 1'b1; t++) @(posedge clk_sys);
    check_flag(te, 1'b1);
    if (te === 1'b1) begin
      host.scan(w, w1, w2);
      check_word(w, 18'h00000);
      check_word(w1, {17'h00000, line[8]});
      check_word(w2, {10'h000, line[7:0]});
      check_flag(te, 1'b1);
      for (t = 0; t < 4100 && te !== 1'b0; t++) @(posedge clk_sys);
      check_flag(te, 1'b0);
    end
    end_of_test();
  end
endmodule
